// ---- cpu_mode_state.v ----
// cpu privilege, mode, banked stack, status word and exception mask state with apb access
`timescale 1ns/1ps
`include "cpu_state_regs.vh"

// Contract
// - handler mode exists only privileged; three legal states total
// - user level access to restricted registers or instructions is blocked and faults
// - handler mode while servicing an exception, thread mode otherwise
// - all sixteen core registers are 32 bits wide
// - registers 8 to 12 not reachable by 16-bit encodings; 0 to 7 always
// - stack pointer banked between main and process stack pointers
// - stack pointer low two bits read and store as zero
// - subroutine call stores return address into the return link register
// - program counter bit 0 is forced to zero
// - result flags live in status word bits 27 to 31
// - active exception number shows in status word bits 0 to 8
// - execution state bits live in status bits 10 to 15 and 25 to 26
// - status bit 24 reads one; writing it zero faults
// - all irq mask lets only nonmaskable and hard fault through
// - fault escalation mask lets only nonmaskable through
// - nonzero threshold blocks priority values equal or above it; zero disables
// - control bit 0 selects privileged or user thread execution
// - control bit 1 selects process stack; ignored in handler mode
module cpu_mode_state (
  input wire mclk_i,                 // core clock
  input wire rst_i,                  // synchronous reset, active high
  input wire psel_i,                 // apb select
  input wire penable_i,              // apb enable
  input wire pwrite_i,               // apb direction, high for write
  input wire [7:0] paddr_i,          // apb byte address
  input wire [31:0] pwdata_i,        // apb write data
  output reg [31:0] prdata_o,        // apb read data
  output wire pready_o,              // apb ready
  output wire pslverr_o,             // apb error
  input wire exc_req_i,              // exception request level
  input wire [8:0] exc_num_i,        // requested exception number
  input wire [8:0] exc_prio_i,       // requested priority value
  input wire exc_nmi_i,              // request is the nonmaskable interrupt
  input wire exc_hardfault_i,        // request is the hard fault
  output wire exc_take_o,            // request accepted this cycle
  input wire exc_return_i,           // exception return pulse
  input wire call_i,                 // subroutine call pulse
  input wire [31:0] call_ret_addr_i, // return address of the call
  input wire [3:0] creg_sel_i,       // core register select
  input wire creg_narrow_i,          // access comes from a 16-bit encoding
  input wire creg_we_i,              // core register write
  input wire [31:0] creg_wdata_i,    // core register write data
  output reg [31:0] creg_rdata_o,    // core register read data, one cycle late
  output wire creg_illegal_o,        // select not reachable by this encoding
  input wire flags_we_i,             // result flags update
  input wire [4:0] flags_i,          // new result flags
  input wire priv_instr_i,           // restricted instruction issued
  output wire priv_block_o,          // restricted instruction blocked
  output reg fault_o,                // fault raised, one-cycle pulse
  output wire handler_o,             // handler mode
  output wire user_o,                // user level
  output reg [31:0] sp_o,            // active stack pointer
  output reg [31:0] pc_o,            // program counter
  output wire irq_o                  // level interrupt
);

  localparam ST_HANDLER = 3'b001;
  localparam ST_PRIV_THREAD = 3'b010;
  localparam ST_USER_THREAD = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] gpr_q [0:`GPR_COUNT-1];
  reg [31:0] msp_q;
  reg [31:0] psp_q;
  reg [31:0] lr_q;
  reg [4:0] flags_q;
  reg [1:0] exec_hi_q;
  reg [5:0] exec_lo_q;
  reg [8:0] exc_q;
  reg all_mask_q;
  reg fault_mask_q;
  reg [8:0] prio_thr_q;
  reg [1:0] ctrl_q;
  reg [`EV_WIDTH-1:0] ev_sts_q;
  reg [`EV_WIDTH-1:0] ev_en_q;
  reg [31:0] rd_val;
  reg exc_ok;
  integer i;
  // one register word by core index; words come in as arguments so @* callers see changes
  function [31:0] core_word;
    input [3:0] idx;
    input [31:0] gw, spw, lrw, pcw;
    begin
      if (idx == `IDX_SP)
        core_word = spw;
      else if (idx == `IDX_LR)
        core_word = lrw;
      else if (idx == `IDX_PC)
        core_word = pcw;
      else
        core_word = gw;
    end
  endfunction
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'h0) && (a <= `A_IRQ_EN);
    end
  endfunction
  function is_restricted;
    input [7:0] a;
    begin
      is_restricted = (a >= `A_STATUS);
    end
  endfunction
  wire handler = state_q[0];
  wire user_thread = state_q[2];
  // process stack only in thread mode with alternate selected
  wire use_psp = ~handler & ctrl_q[`CTRL_ALT_SP];
  wire [31:0] status_word = {flags_q, exec_hi_q, 1'b1, 8'h00, exec_lo_q, 1'b0, exc_q};
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire mapped = is_mapped(paddr_i);
  // user level blocked from special registers
  wire denied = user_thread & is_restricted(paddr_i);
  // clearing the compact bit is refused
  wire bad_status = pwrite_i & (paddr_i == `A_STATUS) & ~pwdata_i[`ST_COMPACT];
  wire bus_err = access & (~mapped | denied | bad_status);
  wire wr_ok = access & pwrite_i & mapped & ~denied & ~bad_status;
  wire gpr_bus = wr_ok & (paddr_i < `A_STATUS);
  wire [3:0] bus_idx = paddr_i[5:2];
  assign pready_o = 1'b1;
  assign pslverr_o = bus_err;
  assign handler_o = handler;
  assign user_o = user_thread;
  assign irq_o = |(ev_sts_q & ev_en_q);
  // high registers unreachable from narrow encodings
  assign creg_illegal_o = creg_narrow_i & (creg_sel_i >= `HIGH_LO) & (creg_sel_i <= `HIGH_HI);
  wire core_wr = creg_we_i & ~creg_illegal_o;
  // restricted instructions blocked at user level
  assign priv_block_o = priv_instr_i & user_thread;
  wire fault_ev = bus_err & (denied | bad_status) | priv_block_o | (creg_we_i & creg_illegal_o);
  always @*
  begin
    exc_ok = 1'b0;
    if (exc_nmi_i)
      exc_ok = 1'b1;
    // escalation mask stops everything but the nonmaskable
    else if (fault_mask_q)
      exc_ok = 1'b0;
    // irq mask leaves only hard fault
    else if (exc_hardfault_i)
      exc_ok = 1'b1;
    else if (all_mask_q)
      exc_ok = 1'b0;
    else
      exc_ok = (prio_thr_q == `RST_PRIO) || (exc_prio_i < prio_thr_q);
  end

  assign exc_take_o = exc_req_i & exc_ok;
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_HANDLER:
      begin
        if (exc_return_i & ~exc_take_o)
          state_d = ctrl_q[`CTRL_USER] ? ST_USER_THREAD : ST_PRIV_THREAD;
      end
      ST_PRIV_THREAD:
      begin
        if (exc_take_o)
          state_d = ST_HANDLER;
        else if (wr_ok & (paddr_i == `A_MODE_CTRL) & pwdata_i[`CTRL_USER])
          state_d = ST_USER_THREAD;
      end
      ST_USER_THREAD:
      begin
        if (exc_take_o)
          state_d = ST_HANDLER;
      end
      default:
        state_d = ST_PRIV_THREAD;
    endcase
  end

  always @*
  begin
    rd_val = `RST_WORD;
    if (paddr_i < `A_STATUS)
      rd_val = core_word(bus_idx, gpr_q[bus_idx], sp_o, lr_q, pc_o);
    else
    begin
      case (paddr_i)
        `A_STATUS: rd_val = status_word;
        `A_ALL_MASK: rd_val = {31'h00000000, all_mask_q};
        `A_FAULT_MASK: rd_val = {31'h00000000, fault_mask_q};
        `A_PRIO_THR: rd_val = {23'h000000, prio_thr_q};
        `A_MODE_CTRL: rd_val = {30'h00000000, ctrl_q};
        `A_MAIN_SP: rd_val = msp_q;
        `A_PROC_SP: rd_val = psp_q;
        `A_IRQ_STS: rd_val = {{(32-`EV_WIDTH){1'b0}}, ev_sts_q};
        `A_IRQ_EN: rd_val = {{(32-`EV_WIDTH){1'b0}}, ev_en_q};
        default: rd_val = `RST_WORD;
      endcase
    end
  end

  // read data captured in setup so the access phase answers from a flop
  always @(posedge mclk_i)
  begin
    if (rst_i)
      prdata_o <= `RST_WORD;
    else if (setup & ~pwrite_i)
      prdata_o <= (is_mapped(paddr_i) & ~denied) ? rd_val : `RST_WORD;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      state_q <= ST_PRIV_THREAD;
    else
      state_q <= state_d;
  end

  // thirteen 32-bit general registers; core writes win over the bus
  always @(posedge mclk_i)
  begin
    for (i = 0; i < `GPR_COUNT; i = i + 1)
    begin
      if (rst_i)
        gpr_q[i] <= `RST_WORD;
      else if (core_wr & (creg_sel_i == i[3:0]))
        gpr_q[i] <= creg_wdata_i;
      else if (gpr_bus & (bus_idx == i[3:0]))
        gpr_q[i] <= pwdata_i;
    end
  end

  wire sp_core = core_wr & (creg_sel_i == `IDX_SP);
  wire sp_bus = gpr_bus & (bus_idx == `IDX_SP);
  wire [31:0] sp_new = sp_core ? creg_wdata_i : pwdata_i;

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      msp_q <= `RST_WORD;
      psp_q <= `RST_WORD;
    end
    else
    begin
      if ((sp_core | sp_bus) & ~use_psp)
        msp_q <= {sp_new[31:2], 2'h0};
      else if (wr_ok & (paddr_i == `A_MAIN_SP))
        msp_q <= {pwdata_i[31:2], 2'h0};
      if ((sp_core | sp_bus) & use_psp)
        psp_q <= {sp_new[31:2], 2'h0};
      else if (wr_ok & (paddr_i == `A_PROC_SP))
        psp_q <= {pwdata_i[31:2], 2'h0};
    end
  end

  always @*
  begin
    sp_o = use_psp ? psp_q : msp_q;
  end

  // call loads the return link ahead of register writes
  always @(posedge mclk_i)
  begin
    if (rst_i)
      lr_q <= `RST_WORD;
    else if (call_i)
      lr_q <= call_ret_addr_i;
    else if (core_wr & (creg_sel_i == `IDX_LR))
      lr_q <= creg_wdata_i;
    else if (gpr_bus & (bus_idx == `IDX_LR))
      lr_q <= pwdata_i;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      pc_o <= `RST_WORD;
    else if (core_wr & (creg_sel_i == `IDX_PC))
      pc_o <= {creg_wdata_i[31:1], 1'b0};
    else if (gpr_bus & (bus_idx == `IDX_PC))
      pc_o <= {pwdata_i[31:1], 1'b0};
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      creg_rdata_o <= `RST_WORD;
    else
      creg_rdata_o <= core_word(creg_sel_i, gpr_q[creg_sel_i], sp_o, lr_q, pc_o);
  end

  wire st_wr = wr_ok & (paddr_i == `A_STATUS);

  // flags and execution state; the core beats the bus
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      flags_q <= 5'h00;
      exec_hi_q <= 2'h0;
      exec_lo_q <= 6'h00;
    end
    else
    begin
      if (flags_we_i)
        flags_q <= flags_i;
      else if (st_wr)
        flags_q <= pwdata_i[`ST_FLAGS_HI:`ST_FLAGS_LO];
      if (st_wr)
      begin
        exec_hi_q <= pwdata_i[`ST_EXEC_HI_HI:`ST_EXEC_HI_LO];
        exec_lo_q <= pwdata_i[`ST_EXEC_LO_HI:`ST_EXEC_LO_LO];
      end
    end
  end

  // exception number follows entry and clears on return to thread
  always @(posedge mclk_i)
  begin
    if (rst_i)
      exc_q <= `RST_EXC;
    else if (exc_take_o)
      exc_q <= exc_num_i;
    else if (exc_return_i & handler)
      exc_q <= `RST_EXC;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      all_mask_q <= 1'b0;
      fault_mask_q <= 1'b0;
      prio_thr_q <= `RST_PRIO;
    end
    else
    begin
      if (wr_ok & (paddr_i == `A_ALL_MASK))
        all_mask_q <= pwdata_i[0];
      if (wr_ok & (paddr_i == `A_FAULT_MASK))
        fault_mask_q <= pwdata_i[0];
      if (wr_ok & (paddr_i == `A_PRIO_THR))
        prio_thr_q <= pwdata_i[8:0];
    end
  end

  // alternate stack bit cannot be set from handler mode
  // control is kept across entry so return resumes it
  always @(posedge mclk_i)
  begin
    if (rst_i)
      ctrl_q <= `RST_CTRL;
    else if (wr_ok & (paddr_i == `A_MODE_CTRL))
    begin
      ctrl_q[`CTRL_USER] <= pwdata_i[`CTRL_USER];
      if (~handler)
        ctrl_q[`CTRL_ALT_SP] <= pwdata_i[`CTRL_ALT_SP];
    end
  end

  wire [`EV_WIDTH-1:0] ev_set;
  assign ev_set[`EV_ENTRY] = exc_take_o;
  assign ev_set[`EV_RETURN] = exc_return_i & handler & ~exc_take_o;
  assign ev_set[`EV_ACCESS] = fault_ev & ~(bus_err & bad_status & ~denied);
  assign ev_set[`EV_COMPACT] = bus_err & bad_status & ~denied;
  wire [`EV_WIDTH-1:0] ev_clr = (wr_ok & (paddr_i == `A_IRQ_CLR)) ?
                                pwdata_i[`EV_WIDTH-1:0] : `RST_EV;

  // set beats clear in the same cycle so no event is lost
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ev_sts_q <= `RST_EV;
      ev_en_q <= `RST_EV;
      fault_o <= 1'b0;
    end
    else
    begin
      ev_sts_q <= (ev_sts_q & ~ev_clr) | ev_set;
      if (wr_ok & (paddr_i == `A_IRQ_EN))
        ev_en_q <= pwdata_i[`EV_WIDTH-1:0];
      // blocked accesses raise a fault pulse
      fault_o <= fault_ev;
    end
  end

endmodule

// ---- cpu_mode_state_properties.sv ----
// port level checks for the cpu mode and privilege state block
`timescale 1ns/1ps
module cpu_mode_state_properties (
  input wire mclk_i,             // core clock
  input wire rst_i,              // synchronous reset
  input wire exc_req_i,          // exception request
  input wire exc_nmi_i,          // nonmaskable request
  input wire exc_take_o,         // request accepted
  input wire exc_return_i,       // exception return
  input wire [3:0] creg_sel_i,   // core register select
  input wire creg_narrow_i,      // 16-bit encoding
  input wire creg_we_i,          // core register write
  input wire creg_illegal_o,     // select unreachable
  input wire priv_instr_i,       // restricted instruction
  input wire priv_block_o,       // instruction blocked
  input wire fault_o,            // fault pulse
  input wire handler_o,          // handler mode
  input wire user_o,             // user level
  input wire [31:0] sp_o,        // active stack pointer
  input wire [31:0] pc_o         // program counter
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_handler_priv: assert property (handler_o |-> !user_o)
    else $error("user level seen in handler mode");
  a_priv_block: assert property (priv_block_o == (priv_instr_i && user_o && !handler_o))
    else $error("restricted instruction block wrong");
  a_block_fault: assert property (priv_block_o |=> fault_o)
    else $error("blocked instruction gave no fault");
  a_take_handler: assert property (exc_take_o |=> handler_o && !user_o)
    else $error("accepted exception did not enter handler");
  a_return_thread: assert property (exc_return_i && !exc_take_o |=> !handler_o)
    else $error("return left core in handler mode");
  a_thread_holds: assert property (!handler_o && !exc_take_o |=> !handler_o)
    else $error("handler mode without exception");
  a_sp_aligned: assert property (sp_o[1:0] == 2'h0)
    else $error("stack pointer not word aligned");
  a_pc_aligned: assert property (pc_o[0] == 1'b0)
    else $error("program counter odd");
  a_narrow_high: assert property (creg_illegal_o ==
    (creg_narrow_i && creg_sel_i >= 4'h8 && creg_sel_i <= 4'hC))
    else $error("narrow select legality wrong");
  a_narrow_fault: assert property (creg_illegal_o && creg_we_i |=> fault_o)
    else $error("narrow high write gave no fault");
  a_nmi_taken: assert property (exc_req_i && exc_nmi_i |-> exc_take_o)
    else $error("nonmaskable request refused");
endmodule

bind cpu_mode_state cpu_mode_state_properties u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .exc_req_i(exc_req_i), .exc_nmi_i(exc_nmi_i), .exc_take_o(exc_take_o),
  .exc_return_i(exc_return_i), .creg_sel_i(creg_sel_i), .creg_narrow_i(creg_narrow_i),
  .creg_we_i(creg_we_i), .creg_illegal_o(creg_illegal_o), .priv_instr_i(priv_instr_i),
  .priv_block_o(priv_block_o), .fault_o(fault_o), .handler_o(handler_o), .user_o(user_o),
  .sp_o(sp_o), .pc_o(pc_o));

// ---- cpu_state_regs.vh ----
// register offsets, field positions, reset values and codes for the cpu state block
`ifndef CPU_STATE_REGS_VH
`define CPU_STATE_REGS_VH

// byte addresses on the register bus
`define A_GPR0        8'h00
`define A_SP          8'h34
`define A_LR          8'h38
`define A_PC          8'h3C
`define A_STATUS      8'h40
`define A_ALL_MASK    8'h44
`define A_FAULT_MASK  8'h48
`define A_PRIO_THR    8'h4C
`define A_MODE_CTRL   8'h50
`define A_MAIN_SP     8'h54
`define A_PROC_SP     8'h58
`define A_IRQ_STS     8'h5C
`define A_IRQ_CLR     8'h60
`define A_IRQ_EN      8'h64

// register file shape
`define GPR_COUNT     13
`define IDX_SP        4'hD
`define IDX_LR        4'hE
`define IDX_PC        4'hF
`define HIGH_LO       4'h8
`define HIGH_HI       4'hC

// combined status word fields
`define ST_FLAGS_HI   31
`define ST_FLAGS_LO   27
`define ST_EXEC_HI_HI 26
`define ST_EXEC_HI_LO 25
`define ST_COMPACT    24
`define ST_EXEC_LO_HI 15
`define ST_EXEC_LO_LO 10
`define ST_EXC_HI     8
`define ST_EXC_LO     0

// mode control fields
`define CTRL_USER     0
`define CTRL_ALT_SP   1

// event bits of the interrupt status register
`define EV_ENTRY      0
`define EV_RETURN     1
`define EV_ACCESS     2
`define EV_COMPACT    3
`define EV_WIDTH      4

// reset values
`define RST_WORD      32'h00000000
`define RST_CTRL      2'h0
`define RST_PRIO      9'h000
`define RST_EXC       9'h000
`define RST_EV        4'h0

`endif

// ---- tb_top.sv ----
// self-checking bench for the cpu mode and privilege state block
`timescale 1ns/1ps
`include "cpu_state_regs.vh"
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, call_ret_addr_i, creg_wdata_i, creg_rdata_o, sp_o, pc_o, rd;
  logic exc_req_i, exc_nmi_i, exc_hardfault_i, exc_take_o, exc_return_i, call_i;
  logic [8:0] exc_num_i, exc_prio_i;
  logic creg_narrow_i, creg_we_i, creg_illegal_o, flags_we_i, priv_instr_i, irq_o;
  logic priv_block_o, fault_o, handler_o, user_o;
  logic [3:0] creg_sel_i;
  logic [4:0] flags_i;
  int failures, n_compared;

  cpu_mode_state u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .exc_req_i(exc_req_i),
    .exc_num_i(exc_num_i), .exc_prio_i(exc_prio_i), .exc_nmi_i(exc_nmi_i),
    .exc_hardfault_i(exc_hardfault_i), .exc_take_o(exc_take_o), .exc_return_i(exc_return_i),
    .call_i(call_i), .call_ret_addr_i(call_ret_addr_i), .creg_sel_i(creg_sel_i),
    .creg_narrow_i(creg_narrow_i), .creg_we_i(creg_we_i), .creg_wdata_i(creg_wdata_i),
    .creg_rdata_o(creg_rdata_o), .creg_illegal_o(creg_illegal_o), .flags_we_i(flags_we_i),
    .flags_i(flags_i), .priv_instr_i(priv_instr_i), .priv_block_o(priv_block_o),
    .fault_o(fault_o), .handler_o(handler_o), .user_o(user_o), .sp_o(sp_o), .pc_o(pc_o),
    .irq_o(irq_o));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  // request held until pready is sampled high, then one idle edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      failures++;
      tally_and_finish();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(n, e, rd)
  endtask

  task exc(input logic nmi, input logic hf, input logic [8:0] num, input logic [8:0] pr,
           input logic e);
    exc_req_i <= 1'b1;
    exc_nmi_i <= nmi;
    exc_hardfault_i <= hf;
    exc_num_i <= num;
    exc_prio_i <= pr;
    // combinational answer read at the edge that takes it, before that edge updates flops
    @(posedge mclk_i);
    `CHK("take", e, exc_take_o)
    exc_req_i <= 1'b0;
    @(posedge mclk_i);
    if (e) `CHK("handler", 1'b1, handler_o)
  endtask

  task ret;
    exc_return_i <= 1'b1;
    @(posedge mclk_i);
    exc_return_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task cr(input logic [3:0] s, input logic nw, input logic we, input logic [31:0] d);
    creg_sel_i <= s;
    creg_narrow_i <= nw;
    creg_we_i <= we;
    creg_wdata_i <= d;
    @(posedge mclk_i);
    `CHK("illegal", nw && s >= 4'h8 && s <= 4'hC, creg_illegal_o)
    creg_we_i <= 1'b0;
    // idle edge so a following call never re-drives the write strobe in this step
    @(posedge mclk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    failures = 0;
    n_compared = 0;
    {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, call_ret_addr_i} = '0;
    {exc_req_i, exc_nmi_i, exc_hardfault_i, exc_return_i, call_i, exc_num_i, exc_prio_i} = 0;
    {creg_sel_i, creg_narrow_i, creg_we_i, creg_wdata_i, flags_we_i, flags_i} = 0;
    priv_instr_i = 1'b0;
    rst_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rdchk("status", `A_STATUS, 32'h01000000);
    rdchk("control", `A_MODE_CTRL, 32'h00000000);
    `CHK("user", 1'b0, user_o)
    done("reset");
    wr(`A_STATUS, 32'hFF00FDFF);
    rdchk("status", `A_STATUS, 32'hFF00FC00);
    wr(`A_STATUS, 32'h00000000);
    rdchk("status", `A_STATUS, 32'hFF00FC00);
    flags_i <= 5'h15;
    flags_we_i <= 1'b1;
    @(posedge mclk_i);
    flags_we_i <= 1'b0;
    rdchk("flags", `A_STATUS, 32'hAF00FC00);
    rdchk("events", `A_IRQ_STS, 32'h00000008);
    apb(1'b0, 8'h68, 32'h0);
    `CHK("unmapped", 1'b1, err)
    done("status");
    wr(`A_MAIN_SP, 32'h00001003);
    wr(`A_PROC_SP, 32'h00002002);
    wr(`A_PC, 32'h00000301);
    rdchk("msp", `A_MAIN_SP, 32'h00001000);
    `CHK("sp", 32'h00001000, sp_o)
    `CHK("pc", 32'h00000300, pc_o)
    cr(4'hC, 1'b0, 1'b1, 32'hC0DE0012);
    rdchk("r12", 8'h30, 32'hC0DE0012);
    cr(4'h9, 1'b1, 1'b1, 32'h00000001);
    rdchk("r9", 8'h24, 32'h00000000);
    cr(4'h7, 1'b1, 1'b1, 32'h00000077);
    cr(4'h7, 1'b1, 1'b0, 32'h00000000);
    `CHK("rdata", 32'h00000077, creg_rdata_o)
    call_ret_addr_i <= 32'h00004567;
    call_i <= 1'b1;
    @(posedge mclk_i);
    call_i <= 1'b0;
    rdchk("link", `A_LR, 32'h00004567);
    done("core registers");
    wr(`A_IRQ_CLR, 32'h0000000F);
    wr(`A_ALL_MASK, 32'h1);
    exc(1'b0, 1'b0, 9'h010, 9'h005, 1'b0);
    exc(1'b0, 1'b1, 9'h003, 9'h005, 1'b1);
    ret();
    exc(1'b1, 1'b0, 9'h002, 9'h005, 1'b1);
    ret();
    wr(`A_ALL_MASK, 32'h0);
    wr(`A_FAULT_MASK, 32'h1);
    exc(1'b0, 1'b1, 9'h003, 9'h005, 1'b0);
    exc(1'b1, 1'b0, 9'h002, 9'h005, 1'b1);
    ret();
    wr(`A_FAULT_MASK, 32'h0);
    wr(`A_PRIO_THR, 32'h10);
    exc(1'b0, 1'b0, 9'h011, 9'h010, 1'b0);
    exc(1'b0, 1'b0, 9'h011, 9'h020, 1'b0);
    exc(1'b0, 1'b0, 9'h011, 9'h00F, 1'b1);
    ret();
    wr(`A_PRIO_THR, 32'h0);
    exc(1'b0, 1'b0, 9'h011, 9'h1FF, 1'b1);
    apb(1'b0, `A_STATUS, 32'h0);
    `CHK("excnum", 9'h011, rd[8:0])
    rdchk("events", `A_IRQ_STS, 32'h00000003);
    `CHK("irq", 1'b0, irq_o)
    wr(`A_IRQ_EN, 32'h1);
    `CHK("irq", 1'b1, irq_o)
    wr(`A_IRQ_CLR, 32'h3);
    `CHK("irq", 1'b0, irq_o)
    ret();
    `CHK("handler", 1'b0, handler_o)
    done("masks");
    wr(`A_MODE_CTRL, 32'h2);
    `CHK("sp", 32'h00002000, sp_o)
    exc(1'b0, 1'b0, 9'h005, 9'h000, 1'b1);
    `CHK("sp", 32'h00001000, sp_o)
    ret();
    `CHK("sp", 32'h00002000, sp_o)
    wr(`A_MODE_CTRL, 32'h3);
    `CHK("user", 1'b1, user_o)
    `CHK("sp", 32'h00002000, sp_o)
    apb(1'b0, `A_STATUS, 32'h0);
    `CHK("user err", 1'b1, err)
    `CHK("user rd", 32'h00000000, rd)
    priv_instr_i <= 1'b1;
    @(posedge mclk_i);
    `CHK("block", 1'b1, priv_block_o)
    priv_instr_i <= 1'b0;
    exc(1'b0, 1'b0, 9'h007, 9'h000, 1'b1);
    `CHK("user", 1'b0, user_o)
    apb(1'b0, `A_IRQ_STS, 32'h0);
    `CHK("access event", 1'b1, rd[2])
    ret();
    `CHK("user", 1'b1, user_o)
    done("privilege");
    tally_and_finish();
  end
endmodule
